// ==== rtl/gpio_od_pkg.sv ====
package gpio_od_pkg;
    // ==========================================================
    // Bus and register geometry
    localparam int DataWidth = 32;
    localparam int AddrWidth = 32;
    localparam logic [31:0] AddrPinOutputValue = 32'hEF600700;
    localparam logic [31:0] AddrPinDriveEnable = 32'hEF600704;
    localparam logic [31:0] AddrPinOpenDrainSelect = 32'hEF600718;
    localparam logic [31:0] AddrPinInputSample = 32'hEF60071C;
    // ==========================================================
    // Pin field layout: bits 1..23 carry pins, rest reserved
    localparam int PinLow = 1;
    localparam int PinHigh = 23;
    localparam logic [31:0] PinMask = 32'h00FFFFFE;
    localparam logic [31:0] RegResetValue = 32'h00000000;
    localparam logic [31:0] ReadZero = 32'h00000000;
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_OUT = 3'b001,
        SEL_TS = 3'b010,
        SEL_OD = 3'b011,
        SEL_IN = 3'b100
    } reg_sel_t;
endpackage

// ==== rtl/pin_sync_if.sv ====
`timescale 1ns/100ps
// Carries raw pad input in and the synchronised word out
interface pin_sync_if;
    logic [31:0] rawIn;
    logic [31:0] syncOut;
    modport owner (output rawIn, input syncOut);
    modport syncer (input rawIn, output syncOut);
endinterface

// ==== rtl/pin_input_sync.sv ====
`timescale 1ns/100ps
module pin_input_sync (
    // Clock
    input wire logic clk,
    input wire logic clkEn,
    // Data
    pin_sync_if.syncer sio
);
    import gpio_od_pkg::*;
    logic [31:0] stage1;
    logic [31:0] stage2;
    logic [31:0] next_stage1;
    logic [31:0] next_stage2;

    // ==========================================================
    // Two-flop synchroniser, no reset so it tracks the pads whenever clkEn is high
    always_comb begin
        next_stage1 = stage1;
        next_stage2 = stage2;
        if (clkEn) begin
            next_stage1 = sio.rawIn;
            next_stage2 = stage1;
        end
    end

    // Registers only
    always_ff @(posedge clk) begin
        stage1 <= next_stage1;
        stage2 <= next_stage2;
    end

    assign sio.syncOut = stage2;
endmodule

// ==== rtl/gpio_open_drain_port.sv ====
`timescale 1ns/100ps
module gpio_open_drain_port (
    // Clock, enable and reset
    input wire logic clk,
    input wire logic clkEn,
    input wire logic rst,
    // Peripheral bus slave
    input wire logic busSelect,
    input wire logic busWrite,
    input wire logic [gpio_od_pkg::AddrWidth-1:0] busAddr,
    input wire logic [gpio_od_pkg::DataWidth-1:0] busWrData,
    output logic [gpio_od_pkg::DataWidth-1:0] busRdData,
    output logic busAck,
    // Pads
    input wire logic [31:0] pinIn,
    output logic [31:0] pinOut,
    output logic [31:0] pin_driver_enable_out
);
    import gpio_od_pkg::*;

    // ==========================================================
    // Address decode
    function automatic reg_sel_t decode(input logic [31:0] a);
        reg_sel_t s;
        s = SEL_NONE;
        if (a == AddrPinOutputValue) begin
            s = SEL_OUT;
        end else if (a == AddrPinDriveEnable) begin
            s = SEL_TS;
        end else if (a == AddrPinOpenDrainSelect) begin
            s = SEL_OD;
        end else if (a == AddrPinInputSample) begin
            s = SEL_IN;
        end
        return s;
    endfunction

    // ==========================================================
    // State
    logic [31:0] pin_output_value;
    logic [31:0] pin_drive_enable;
    logic [31:0] pin_open_drain_select;
    logic [31:0] pin_input_sample;
    logic [31:0] next_pin_output_value;
    logic [31:0] next_pin_drive_enable;
    logic [31:0] next_pin_open_drain_select;
    logic [31:0] next_pin_input_sample;
    logic [31:0] next_busRdData;
    logic next_busAck;
    logic [31:0] next_pinOut;
    logic [31:0] next_pinEn;
    logic [31:0] syncedIn;
    reg_sel_t sel;

    pin_sync_if sio();
    assign sio.rawIn = pinIn;
    assign syncedIn = sio.syncOut;

    // Two-flop synchroniser on all pad inputs
    pin_input_sync u_sync (
        .clk(clk),
        .clkEn(clkEn),
        .sio(sio)
    );

    assign sel = decode(busAddr);

    // ==========================================================
    // Register writes and bus read mux
    always_comb begin
        next_pin_output_value = pin_output_value;
        next_pin_drive_enable = pin_drive_enable;
        next_pin_open_drain_select = pin_open_drain_select;
        next_busRdData = ReadZero;
        next_busAck = 1'b0;
        if (busSelect) begin
            next_busAck = 1'b1;
            if (busWrite) begin
                // Input sample ignores writes; unmapped writes dropped
                if (sel == SEL_OUT) begin
                    next_pin_output_value = busWrData & PinMask;
                end else if (sel == SEL_TS) begin
                    next_pin_drive_enable = busWrData & PinMask;
                end else if (sel == SEL_OD) begin
                    next_pin_open_drain_select = busWrData & PinMask;
                end
            end else begin
                if (sel == SEL_OUT) begin
                    next_busRdData = pin_output_value;
                end else if (sel == SEL_TS) begin
                    next_busRdData = pin_drive_enable;
                end else if (sel == SEL_OD) begin
                    next_busRdData = pin_open_drain_select;
                end else if (sel == SEL_IN) begin
                    next_busRdData = pin_input_sample;
                end
            end
        end
        if (rst) begin
            next_pin_output_value = RegResetValue;
            next_pin_drive_enable = RegResetValue;
            next_pin_open_drain_select = RegResetValue;
            next_busRdData = ReadZero;
            next_busAck = 1'b0;
        end
    end

    // Input sample never reset, so it is valid right after reset
    always_comb begin
        next_pin_input_sample = syncedIn & PinMask;
    end

    // ==========================================================
    // Pad output logic, per pin
    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_pin
            always_comb begin
                if (pin_open_drain_select[i]) begin
                    next_pinOut[i] = 1'b0;
                    next_pinEn[i] = ~pin_output_value[i];
                end else begin
                    next_pinOut[i] = pin_output_value[i];
                    next_pinEn[i] = pin_drive_enable[i];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Registers; pads follow the register values one cycle late
    always_ff @(posedge clk) begin
        if (clkEn) begin
            pin_output_value <= next_pin_output_value;
            pin_drive_enable <= next_pin_drive_enable;
            pin_open_drain_select <= next_pin_open_drain_select;
            busRdData <= next_busRdData;
            busAck <= next_busAck;
        end
    end

    always_ff @(posedge clk) begin
        if (clkEn) begin
            pin_input_sample <= next_pin_input_sample;
        end
    end

    // Enable zero floats the pad; the pad cell honours it over data
    always_ff @(posedge clk) begin
        if (clkEn) begin
            if (rst) begin
                pinOut <= RegResetValue;
                pin_driver_enable_out <= RegResetValue;
            end else begin
                pinOut <= next_pinOut;
                pin_driver_enable_out <= next_pinEn;
            end
        end
    end
endmodule

// ==== tb/gpio_pad_model.sv ====
`timescale 1ns/100ps
module gpio_pad_model (
    // From the port
    input wire logic [31:0] dataOut,
    input wire logic [31:0] driveEn,
    // Outside level where nothing drives
    input wire logic [31:0] padExt,
    // Back to the port
    output logic [31:0] padIn
);
    // Enabled bit shows its data, a floating bit takes the outside level
    assign padIn = (dataOut & driveEn) | (padExt & ~driveEn);
endmodule

// ==== tb/gpio_od_props.sv ====
`timescale 1ns/100ps
module gpio_od_props
    import gpio_od_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic clkEn,
    input wire logic rst,
    // Bus
    input wire logic busSelect,
    input wire logic busWrite,
    input wire logic [31:0] busAddr,
    input wire logic [31:0] busWrData,
    input wire logic [31:0] busRdData,
    input wire logic busAck,
    // Pads
    input wire logic [31:0] pinIn,
    input wire logic [31:0] pinOut,
    input wire logic [31:0] pin_driver_enable_out
);
    logic [31:0] outS, tsS, odS;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Shadow registers, so pin outputs can be judged from bus history
    always_ff @(posedge clk) begin
        if (rst) begin
            outS <= 32'h0;
            tsS <= 32'h0;
            odS <= 32'h0;
        end else if (clkEn && busSelect && busWrite) begin
            if (busAddr == AddrPinOutputValue) outS <= busWrData & PinMask;
            if (busAddr == AddrPinDriveEnable) tsS <= busWrData & PinMask;
            if (busAddr == AddrPinOpenDrainSelect) odS <= busWrData & PinMask;
        end
    end
    property p_ack; clkEn && busSelect |=> busAck; endproperty
    a_ack: assert property (p_ack) else $error("missing ack");
    property p_idle; clkEn && !busSelect |=> !busAck && busRdData == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("stray ack");
    property p_rsvd; busAck |-> (busRdData & ~PinMask) == 32'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_data; clkEn |=> pinOut == $past(outS & ~odS); endproperty
    a_data: assert property (p_data) else $error("pin data wrong");
    property p_en; clkEn |=> pin_driver_enable_out == $past((tsS & ~odS) | (~outS & odS));
    endproperty
    a_en: assert property (p_en) else $error("pin enable wrong");
    property p_rst; disable iff (1'b0)
        rst && clkEn |=> pinOut == 32'h0 && pin_driver_enable_out == 32'h0 && !busAck;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_sync; (clkEn && $stable(pinIn))[*4] ##0
        (busSelect && !busWrite && busAddr == AddrPinInputSample)
        |=> busRdData == ($past(pinIn) & PinMask); endproperty
    a_sync: assert property (p_sync) else $error("input sample wrong");
    property p_rdTs; busAck && $past(clkEn && busSelect && !busWrite
        && busAddr == AddrPinDriveEnable) |-> busRdData == $past(tsS); endproperty
    a_rdTs: assert property (p_rdTs) else $error("readback wrong");
endmodule
bind gpio_open_drain_port gpio_od_props i_props (.clk(clk), .clkEn(clkEn), .rst(rst),
    .busSelect(busSelect), .busWrite(busWrite), .busAddr(busAddr), .busWrData(busWrData),
    .busRdData(busRdData), .busAck(busAck), .pinIn(pinIn), .pinOut(pinOut),
    .pin_driver_enable_out(pin_driver_enable_out));

// ==== tb/gpio_open_drain_port_tb_top.sv ====
`timescale 1ns/100ps
module gpio_open_drain_port_tb_top;
    import gpio_od_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    logic busSelect = 1'b0;
    logic busWrite = 1'b0;
    logic [31:0] busAddr = 32'h0;
    logic [31:0] busWrData = 32'h0;
    logic [31:0] padExt = 32'h0;
    logic [31:0] busRdData, pinIn, pinOut, drvEn, r, x;
    logic busAck;
    logic [32:0] expQ[$];
    logic [32:0] e;
    logic [31:0] regA[3] = '{AddrPinOutputValue, AddrPinDriveEnable, AddrPinOpenDrainSelect};
    int n_mismatch = 0;
    int checked = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    gpio_open_drain_port i_dut (.clk(clk), .clkEn(clkEn), .rst(rst), .busSelect(busSelect),
        .busWrite(busWrite), .busAddr(busAddr), .busWrData(busWrData), .busRdData(busRdData),
        .busAck(busAck), .pinIn(pinIn), .pinOut(pinOut), .pin_driver_enable_out(drvEn));
    gpio_pad_model i_pads (.dataOut(pinOut), .driveEn(drvEn), .padExt(padExt), .padIn(pinIn));
    // Select stays up after a call, so calls run back to back
    task automatic acc(input logic wr, input logic [31:0] a, d, v);
        @(negedge clk);
        busSelect = 1'b1;
        busWrite = wr;
        busAddr = a;
        busWrData = d;
        expQ.push_back({~wr, v});
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge clk);
            busSelect = 1'b0;
        end
    endtask
    task automatic chk(input logic [31:0] v, got);
        checked++;
        if (got !== v) begin
            n_mismatch++;
            $display("[FAIL] %0t read %h expected %h", $time, got, v);
        end
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Each ack retires the oldest note; only reads carry data
    always @(negedge clk) begin
        if (busAck === 1'b1) begin
            if (expQ.size() == 0) begin
                n_mismatch++;
                $display("[FAIL] %0t ack with no request pending", $time);
            end else begin
                e = expQ.pop_front();
                if (e[32]) chk(e[31:0], busRdData);
            end
        end
    end
    // Main sequence
    initial begin
        void'($urandom(32'h6870));
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 3; i++) acc(1'b0, regA[i], 32'h0, 32'h0);
        for (int i = 0; i < 6; i++) begin
            r = $urandom;
            acc(1'b1, regA[i % 3], r, 32'h0);
            acc(1'b0, regA[i % 3], 32'h0, r & PinMask);
        end
        acc(1'b1, AddrPinInputSample, 32'hFFFFFFFF, 32'h0);
        acc(1'b0, 32'hEF600710, 32'h0, 32'h0);
        // Float, drive and open-drain modes seen back through the pads
        // Pads count as already muxed to this port at chip level
        for (int m = 0; m < 3; m++) begin
            r = $urandom;
            padExt = (m == 2) ? 32'hFFFFFFFF : ~r;
            x = ((m == 0) ? ~r : r) & PinMask;
            acc(1'b1, AddrPinOutputValue, r, 32'h0);
            acc(1'b1, AddrPinDriveEnable, (m > 0) ? 32'hFFFFFFFF : 32'h0, 32'h0);
            acc(1'b1, AddrPinOpenDrainSelect, (m == 2) ? 32'hFFFFFFFF : 32'h0, 32'h0);
            idle(5);
            acc(1'b0, AddrPinInputSample, 32'h0, x);
            acc(1'b0, AddrPinInputSample, 32'h0, x);
        end
        // Sleep: with the enable low a write must neither land nor be acked
        idle(2);
        @(negedge clk);
        clkEn = 1'b0;
        busSelect = 1'b1;
        busWrite = 1'b1;
        busAddr = AddrPinOutputValue;
        busWrData = ~r;
        repeat (3) @(negedge clk);
        busSelect = 1'b0;
        clkEn = 1'b1;
        acc(1'b0, AddrPinOutputValue, 32'h0, r & PinMask);
        idle(3);
        complete_run;
    end
    // Watchdog far beyond the expected run length
    initial begin
        #200000;
        n_mismatch++;
        complete_run;
    end
endmodule
